//--- common/irl_defs.svh
`ifndef IRL_DEFS_SVH
`define IRL_DEFS_SVH
`define IRL_UNMAPPED 8'hFF
`define IRL_SHUT_KEEP0 12'h158
`define IRL_SHUT_KEEP1 12'h15C
`define IRL_TT_READ 4'h0
`define IRL_TT_WRITE 4'h1
`define IRL_CRC_POLY 16'h1021
`define IRL_CRC_INIT 16'hFFFF
`endif

//--- common/irl_pkg.sv
package irl_pkg;
	typedef enum logic [0:0] {IRL_IDLE, IRL_BUS} irl_mstate_t;
endpackage

//--- core/irl_ingress.sv
`timescale 1ns/1ps
`default_nettype none
`include "irl_defs.svh"
module irl_ingress
(
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// configuration
	input wire logic FLAT_LOOKUP_SELECT,
	input wire logic [7:0] LOCAL_GROUP_PREFIX,
	input wire logic [7:0] PORT_TOTAL,
	input wire logic [7:0] DEFAULT_PORT,
	input wire logic PW_EN,
	input wire logic INT_EN,
	input wire logic PORT_SHUT,
	input wire logic [11:0] STAT_ADDR,
	// table access
	input wire logic TBL_WE,
	input wire logic [8:0] TBL_ADDR,
	input wire logic [7:0] TBL_PORT,
	output logic [7:0] TBL_RD_PORT,
	// packet header
	input wire logic PKT_VALID,
	input wire logic [15:0] PKT_DESTID,
	input wire logic PKT_TT16,
	input wire logic PKT_IS_MAINT,
	input wire logic [7:0] PKT_HOP,
	input wire logic [3:0] PKT_TTYPE,
	input wire logic PKT_SIZE4,
	input wire logic [20:0] PKT_OFFSET,
	input wire logic [31:0] PKT_WDATA,
	// routing decision
	output logic ROUTE_VALID,
	output logic [7:0] ROUTE_PORT,
	output logic ROUTE_MAINT_FWD,
	output logic [7:0] ROUTE_HOP,
	output logic [15:0] ROUTE_CRC,
	output logic DROP,
	output logic RETRY,
	// status
	input wire logic CLR_PARITY,
	input wire logic CLR_VENDOR,
	output logic ROUTE_TABLE_PARITY_ERROR,
	output logic VENDOR_SPECIFIC_ERROR_FLAG,
	output logic LOOKUP_VALID_FLAG,
	output logic [15:0] ERR_CAPT_DESTID,
	output logic PW_REQ,
	output logic IRQ,
	output logic [31:0] STAT_RDATA,
	// internal register bus
	output logic RB_REQ,
	output logic RB_WE,
	output logic [20:0] RB_ADDR,
	output logic [31:0] RB_WDATA,
	input wire logic RB_ACK,
	input wire logic RB_ERR,
	input wire logic [31:0] RB_RDATA,
	// maintenance response
	output logic RSP_VALID,
	output logic RSP_OK,
	output logic [31:0] RSP_DATA,
	output logic [15:0] RSP_CRC
);

	function automatic logic [15:0] crc16(input logic [31:0] d);
		logic [15:0] c;
		c = `IRL_CRC_INIT;
		for (int i = 31; i >= 0; i--)
		begin
			if (c[15] ^ d[i])
				c = {c[14:0], 1'b0} ^ `IRL_CRC_POLY;
			else
				c = {c[14:0], 1'b0};
		end
		return c;
	endfunction

	// ----------------------------------------------------------------
	// route table, no reset on contents
	// ----------------------------------------------------------------
	logic [8:0] table_mem [0:511];

	always_ff @(posedge CLK)
	begin
		if (TBL_WE)
			table_mem[TBL_ADDR] <= {^TBL_PORT, TBL_PORT};
	end

	// ----------------------------------------------------------------
	// lookup decode
	// ----------------------------------------------------------------
	wire prefix_hit = PKT_TT16 && (PKT_DESTID[15:8] == LOCAL_GROUP_PREFIX);
	wire [8:0] flat_idx = {PKT_TT16 & PKT_DESTID[8], PKT_DESTID[7:0]};
	wire [8:0] hier_idx = (!PKT_TT16 || prefix_hit) ?
		{1'b0, PKT_DESTID[7:0]} : {1'b1, PKT_DESTID[15:8]};
	wire [8:0] idx = FLAT_LOOKUP_SELECT ? flat_idx : hier_idx;
	wire [8:0] entry = table_mem[idx];
	wire par_bad = ^entry;
	wire unmapped = entry[7:0] > PORT_TOTAL;
	wire def_bad = DEFAULT_PORT > PORT_TOTAL;
	wire [7:0] sel_port = unmapped ? DEFAULT_PORT : entry[7:0];

	irl_pkg::irl_mstate_t state_r;
	irl_pkg::irl_mstate_t state_nxt;

	wire maint_local = PKT_IS_MAINT && (PKT_HOP == 8'h00);
	wire maint_ok = PKT_SIZE4 &&
		(PKT_TTYPE == `IRL_TT_READ || PKT_TTYPE == `IRL_TT_WRITE);
	wire idle = state_r == irl_pkg::IRL_IDLE;
	wire par_evt = PKT_VALID && par_bad;
	wire route_go = PKT_VALID && !maint_local && !par_bad &&
		!(unmapped && def_bad);
	wire discard_def = PKT_VALID && !maint_local && !par_bad &&
		unmapped && def_bad;
	wire retry_evt = PKT_VALID && maint_local && !idle;
	wire start_evt = PKT_VALID && maint_local && idle && maint_ok;
	wire bad_maint = PKT_VALID && maint_local && idle && !maint_ok;
	wire vendor_evt = (route_go && unmapped) || discard_def || bad_maint;
	wire drop_evt = (PKT_VALID && !maint_local && par_bad) ||
		discard_def || bad_maint;
	wire [7:0] hop_dec = PKT_HOP - 8'h01;
	wire fwd_maint = PKT_IS_MAINT && !maint_local;
	wire stat_keep = STAT_ADDR == `IRL_SHUT_KEEP0 ||
		STAT_ADDR == `IRL_SHUT_KEEP1;
	wire [31:0] stat_val = {14'h0000, ERR_CAPT_DESTID,
		LOOKUP_VALID_FLAG, ROUTE_TABLE_PARITY_ERROR};

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			irl_pkg::IRL_IDLE:
				if (start_evt)
					state_nxt = irl_pkg::IRL_BUS;
			irl_pkg::IRL_BUS:
				if (RB_ACK)
					state_nxt = irl_pkg::IRL_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// routing outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			ROUTE_VALID <= 1'b0;
			ROUTE_PORT <= 8'h00;
			ROUTE_MAINT_FWD <= 1'b0;
			ROUTE_HOP <= 8'h00;
			ROUTE_CRC <= 16'h0000;
			DROP <= 1'b0;
			RETRY <= 1'b0;
			TBL_RD_PORT <= 8'h00;
		end
		else
		begin
			ROUTE_VALID <= route_go;
			ROUTE_PORT <= sel_port;
			ROUTE_MAINT_FWD <= route_go && fwd_maint;
			ROUTE_HOP <= fwd_maint ? hop_dec : PKT_HOP;
			ROUTE_CRC <= crc16({PKT_DESTID, hop_dec, 4'h0, PKT_TTYPE});
			DROP <= drop_evt;
			RETRY <= retry_evt;
			TBL_RD_PORT <= PORT_SHUT ? 8'h00 : table_mem[TBL_ADDR][7:0];
		end
	end

	// ----------------------------------------------------------------
	// status, set wins over clear
	// ----------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			ROUTE_TABLE_PARITY_ERROR <= 1'b0;
			VENDOR_SPECIFIC_ERROR_FLAG <= 1'b0;
			LOOKUP_VALID_FLAG <= 1'b0;
			ERR_CAPT_DESTID <= 16'h0000;
			PW_REQ <= 1'b0;
			IRQ <= 1'b0;
			STAT_RDATA <= 32'h0000_0000;
		end
		else
		begin
			ROUTE_TABLE_PARITY_ERROR <= par_evt ||
				(ROUTE_TABLE_PARITY_ERROR && !CLR_PARITY);
			VENDOR_SPECIFIC_ERROR_FLAG <= vendor_evt ||
				(VENDOR_SPECIFIC_ERROR_FLAG && !CLR_VENDOR);
			if (PKT_VALID)
				LOOKUP_VALID_FLAG <= !unmapped;
			if (discard_def)
				ERR_CAPT_DESTID <= PKT_DESTID;
			PW_REQ <= discard_def && PW_EN;
			IRQ <= discard_def && INT_EN;
			STAT_RDATA <= (PORT_SHUT && !stat_keep) ? 32'h0000_0000 :
				stat_val;
		end
	end

	// ----------------------------------------------------------------
	// local maintenance execution and response
	// ----------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			state_r <= irl_pkg::IRL_IDLE;
			RB_REQ <= 1'b0;
			RB_WE <= 1'b0;
			RB_ADDR <= 21'h00_0000;
			RB_WDATA <= 32'h0000_0000;
			RSP_VALID <= 1'b0;
			RSP_OK <= 1'b0;
			RSP_DATA <= 32'h0000_0000;
			RSP_CRC <= 16'h0000;
		end
		else
		begin
			state_r <= state_nxt;
			RSP_VALID <= 1'b0;
			if (start_evt)
			begin
				RB_REQ <= 1'b1;
				RB_WE <= PKT_TTYPE == `IRL_TT_WRITE;
				RB_ADDR <= PKT_OFFSET;
				RB_WDATA <= PKT_WDATA;
			end
			else if (!idle && RB_ACK)
			begin
				RB_REQ <= 1'b0;
				RSP_VALID <= 1'b1;
				RSP_OK <= !RB_ERR;
				RSP_DATA <= RB_WE ? 32'h0000_0000 : RB_RDATA;
				RSP_CRC <= crc16(RB_WE ? 32'h0000_0000 : RB_RDATA);
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_par_drop;
		@(posedge CLK) disable iff (SRST)
		(PKT_VALID && par_bad && !maint_local) |=> DROP && !ROUTE_VALID;
	endproperty
	a_par_drop: assert property (p_par_drop)
		else $error("parity not dropped");

	property p_par_flag;
		@(posedge CLK) disable iff (SRST)
		(PKT_VALID && par_bad) |=> ROUTE_TABLE_PARITY_ERROR;
	endproperty
	a_par_flag: assert property (p_par_flag)
		else $error("parity not flagged");

	property p_default;
		@(posedge CLK) disable iff (SRST)
		route_go && unmapped |=> ROUTE_PORT == $past(DEFAULT_PORT)
			&& VENDOR_SPECIFIC_ERROR_FLAG;
	endproperty
	a_default: assert property (p_default)
		else $error("default not used");

	property p_mapped;
		@(posedge CLK) disable iff (SRST)
		route_go && !unmapped |=> ROUTE_VALID && ROUTE_PORT == $past(entry[7:0]);
	endproperty
	a_mapped: assert property (p_mapped)
		else $error("mapped port wrong");

	property p_hop;
		@(posedge CLK) disable iff (SRST)
		route_go && fwd_maint |=> ROUTE_MAINT_FWD &&
			ROUTE_HOP == $past(PKT_HOP) - 8'h01;
	endproperty
	a_hop: assert property (p_hop)
		else $error("hop not decremented");

	property p_retry;
		@(posedge CLK) disable iff (SRST)
		(PKT_VALID && maint_local && RB_REQ) |=> RETRY;
	endproperty
	a_retry: assert property (p_retry)
		else $error("busy request not retried");

	sequence s_start;
		PKT_VALID && maint_local && maint_ok && idle;
	endsequence
	sequence s_ack;
		RB_REQ && RB_ACK;
	endsequence
	property p_bus;
		@(posedge CLK) disable iff (SRST)
		s_start |=> RB_REQ && RB_ADDR == $past(PKT_OFFSET);
	endproperty
	a_bus: assert property (p_bus)
		else $error("bus request missing");

	property p_rsp;
		@(posedge CLK) disable iff (SRST)
		s_ack |=> RSP_VALID && !RB_REQ && RSP_OK == !$past(RB_ERR);
	endproperty
	a_rsp: assert property (p_rsp)
		else $error("response missing");

	property p_bad_maint;
		@(posedge CLK) disable iff (SRST)
		bad_maint |=> DROP && VENDOR_SPECIFIC_ERROR_FLAG && !RB_REQ;
	endproperty
	a_bad_maint: assert property (p_bad_maint)
		else $error("bad maint kept");

	property p_shut;
		@(posedge CLK) disable iff (SRST)
		PORT_SHUT && !stat_keep |=> STAT_RDATA == 32'h0000_0000
			&& TBL_RD_PORT == 8'h00;
	endproperty
	a_shut: assert property (p_shut)
		else $error("shut port read nonzero");

endmodule
`default_nettype wire

//--- verification/irl_rb_model.sv
`timescale 1ns/1ps
`default_nettype none
module irl_rb_model
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// request side
	input wire logic rb_req,
	input wire logic rb_we,
	input wire logic [20:0] rb_addr,
	// behaviour control
	input wire logic slow,
	input wire logic err_mode,
	// answer side
	output logic rb_ack,
	output logic rb_err,
	output logic [31:0] rb_rdata
);
	// ----
	// register bus responder, idle rb_err and rb_rdata toggle every cycle, rb_ack stays low
	// ----
	logic [3:0] cnt_r;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cnt_r <= 4'h0;
			rb_ack <= 1'b0;
			rb_err <= 1'b0;
			rb_rdata <= 32'h00000000;
		end
		else if (!rb_ack && rb_req && cnt_r == (slow ? 4'h6 : 4'h0))
		begin
			rb_ack <= 1'b1;
			rb_err <= err_mode;
			rb_rdata <= rb_we ? ~rb_rdata : {11'h000, rb_addr} ^ 32'h5A5A0000;
		end
		else
		begin
			rb_ack <= 1'b0;
			rb_err <= ~rb_err;
			rb_rdata <= ~rb_rdata;
			cnt_r <= (rb_req && !rb_ack) ? cnt_r + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

//--- verification/test_ingress_route_lookup_maint.sv
`timescale 1ns/1ps
`default_nettype none
`include "irl_defs.svh"
module test_ingress_route_lookup_maint;
	// ----
	// signals
	// ----
	logic CLK = 0, SRST = 1, FLAT_LOOKUP_SELECT = 0, PW_EN = 0, INT_EN = 0;
	logic PORT_SHUT = 0, TBL_WE = 0, PKT_VALID = 0, PKT_TT16 = 0, PKT_SIZE4 = 0;
	logic PKT_IS_MAINT = 0, CLR_PARITY = 0, CLR_VENDOR = 0, slow = 0;
	logic err_mode = 0;
	logic [7:0] LOCAL_GROUP_PREFIX = 8'h28, PORT_TOTAL = 8'h0C, PKT_HOP = 8'h00;
	logic [7:0] DEFAULT_PORT = 8'h0C, TBL_PORT = 8'h00;
	logic [11:0] STAT_ADDR = 12'h000;
	logic [8:0] TBL_ADDR = 9'h000;
	logic [15:0] PKT_DESTID = 16'h0000;
	logic [3:0] PKT_TTYPE = 4'h0;
	logic [20:0] PKT_OFFSET = 21'h000000;
	logic [31:0] PKT_WDATA = 32'h00000000;
	logic ROUTE_VALID, ROUTE_MAINT_FWD, DROP, RETRY, ROUTE_TABLE_PARITY_ERROR;
	logic VENDOR_SPECIFIC_ERROR_FLAG, LOOKUP_VALID_FLAG, PW_REQ, IRQ, RB_REQ;
	logic RB_WE, RB_ACK, RB_ERR, RSP_VALID, RSP_OK;
	logic [7:0] TBL_RD_PORT, ROUTE_PORT, ROUTE_HOP;
	logic [15:0] ROUTE_CRC, ERR_CAPT_DESTID, RSP_CRC, last_capt;
	logic [20:0] RB_ADDR;
	logic [31:0] STAT_RDATA, RB_WDATA, RB_RDATA, RSP_DATA, r;
	logic [7:0] tbl [0:511];
	int fail_count = 0, n_checks = 0, cyc = 0, i, k;
	integer seed = 78681;

	irl_ingress DUT (.CLK, .SRST, .FLAT_LOOKUP_SELECT, .LOCAL_GROUP_PREFIX,
		.PORT_TOTAL, .DEFAULT_PORT, .PW_EN, .INT_EN, .PORT_SHUT, .STAT_ADDR,
		.TBL_WE, .TBL_ADDR, .TBL_PORT, .TBL_RD_PORT, .PKT_VALID, .PKT_DESTID,
		.PKT_TT16, .PKT_IS_MAINT, .PKT_HOP, .PKT_TTYPE, .PKT_SIZE4, .PKT_OFFSET,
		.PKT_WDATA, .ROUTE_VALID, .ROUTE_PORT, .ROUTE_MAINT_FWD, .ROUTE_HOP,
		.ROUTE_CRC, .DROP, .RETRY, .CLR_PARITY, .CLR_VENDOR,
		.ROUTE_TABLE_PARITY_ERROR, .VENDOR_SPECIFIC_ERROR_FLAG, .LOOKUP_VALID_FLAG,
		.ERR_CAPT_DESTID, .PW_REQ, .IRQ, .STAT_RDATA, .RB_REQ, .RB_WE, .RB_ADDR,
		.RB_WDATA, .RB_ACK, .RB_ERR, .RB_RDATA, .RSP_VALID, .RSP_OK, .RSP_DATA,
		.RSP_CRC);
	irl_rb_model RBM (.clk(CLK), .srst(SRST), .rb_req(RB_REQ), .rb_we(RB_WE),
		.rb_addr(RB_ADDR), .slow(slow), .err_mode(err_mode), .rb_ack(RB_ACK),
		.rb_err(RB_ERR), .rb_rdata(RB_RDATA));

	initial
	begin
		forever #20 CLK = ~CLK;
	end
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			print_verdict;
		end
	end
	// ----
	// helpers
	// ----
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
			fail_count++;
		end
	endtask
	function automatic logic [15:0] crc_of(input logic [31:0] d);
		logic [15:0] c;
		c = `IRL_CRC_INIT;
		for (int b = 31; b >= 0; b--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? `IRL_CRC_POLY : 16'h0000);
		return c;
	endfunction
	function automatic logic [8:0] idx_of(input logic [15:0] d, input logic t);
		if (FLAT_LOOKUP_SELECT)
			return {t & d[8], d[7:0]};
		if (!t || d[15:8] == LOCAL_GROUP_PREFIX)
			return {1'b0, d[7:0]};
		return {1'b1, d[15:8]};
	endfunction
	task send(input logic [15:0] d, input logic t, m, input logic [7:0] h,
		input logic [3:0] tt, input logic s4);
		logic [31:0] q;
		q = $random(seed);
		@(posedge CLK) #1;
		{CLR_VENDOR, CLR_PARITY} = 2'b11;
		@(posedge CLK) #1;
		{CLR_VENDOR, CLR_PARITY, PKT_VALID} = 3'b111;
		{PKT_DESTID, PKT_TT16, PKT_IS_MAINT, PKT_HOP} = {d, t, m, h};
		{PKT_TTYPE, PKT_SIZE4, PKT_OFFSET, PKT_WDATA} = {tt, s4, q[20:0], ~q};
		@(posedge CLK) #1;
		{CLR_VENDOR, CLR_PARITY, PKT_VALID} = 3'b000;
	endtask
	task route(input logic [15:0] d, input logic t, m, input logic [7:0] h);
		logic [7:0] p;
		logic un, dr;
		p = tbl[idx_of(d, t)];
		un = p > PORT_TOTAL;
		p = un ? DEFAULT_PORT : p;
		dr = p > PORT_TOTAL;
		send(d, t, m, h, {3'h0, d[9]}, 1);
		chk(DROP, dr);
		chk(VENDOR_SPECIFIC_ERROR_FLAG, un);
		chk(ROUTE_VALID, !dr);
		chk({PW_REQ, IRQ}, {dr & PW_EN, dr & INT_EN});
		chk(ROUTE_TABLE_PARITY_ERROR, 0);
		chk(LOOKUP_VALID_FLAG, !un);
		if (dr)
			chk(ERR_CAPT_DESTID, d);
		else
			chk(ROUTE_PORT, p);
		last_capt = dr ? d : last_capt;
		if (m)
		begin
			chk(ROUTE_MAINT_FWD, 1);
			chk(ROUTE_HOP, h - 8'h01);
			chk(ROUTE_CRC, crc_of({d, h - 8'h01, 7'h00, d[9]}));
		end
		else
			chk({ROUTE_MAINT_FWD, RETRY}, 0);
	endtask
	task maint0(input logic we, input logic rty);
		logic [31:0] rd;
		logic [20:0] off;
		int n;
		send(r[15:0], 1, 1, 8'h00, {3'h0, we}, 1);
		off = PKT_OFFSET;
		chk({RB_REQ, RB_WE, RB_ADDR}, {1'b1, we, off});
		if (we)
			chk(RB_WDATA, PKT_WDATA);
		if (rty)
		begin
			send(r[31:16], 1, 1, 8'h00, 4'h0, 1);
			chk(RETRY, 1);
		end
		for (n = 0; n < 20 && RB_ACK !== 1'b1; n++)
			@(posedge CLK) #1;
		chk(n < 20, 1);
		@(posedge CLK) #1;
		rd = we ? 32'h00000000 : {11'h000, off} ^ 32'h5A5A0000;
		chk({RSP_VALID, RSP_OK, RB_REQ}, {1'b1, !err_mode, 1'b0});
		chk(RSP_DATA, rd);
		chk(RSP_CRC, crc_of(rd));
	endtask
	// ----
	// main sequence
	// ----
	initial
	begin
		last_capt = 16'h0000;
		repeat (4) @(posedge CLK);
		#1;
		chk({ROUTE_VALID, RB_REQ, RSP_VALID, VENDOR_SPECIFIC_ERROR_FLAG}, 0);
		SRST = 0;
		for (i = 0; i < 512; i++)
		begin
			r = $random(seed);
			tbl[i] = (r[2:0] == 3'h0) ? `IRL_UNMAPPED : {4'h0, r[7:4]};
			{TBL_WE, TBL_ADDR, TBL_PORT} = {1'b1, i[8:0], tbl[i]};
			@(posedge CLK) #1;
		end
		TBL_WE = 0;
		for (i = 0; i < 512; i++)
		begin
			TBL_ADDR = i[8:0];
			@(posedge CLK) #1;
			chk(TBL_RD_PORT, tbl[i]);
		end
		for (k = 0; k < 4; k++)
		begin
			FLAT_LOOKUP_SELECT = k[0];
			DEFAULT_PORT = PORT_TOTAL + {7'h00, k[1]};
			for (i = 0; i < 40; i++)
			begin
				r = $random(seed);
				{PW_EN, INT_EN} = r[21:20];
				route(r[16] ? {LOCAL_GROUP_PREFIX, r[7:0]} : r[15:0], r[17],
					!k[1] & r[18], r[22] ? 8'h01 : r[31:24] | 8'h02);
			end
		end
		for (i = 0; i < 12; i++)
		begin
			r = $random(seed);
			slow = r[0] | (i == 0);
			err_mode = r[1];
			maint0(r[2], slow & (r[3] | (i == 0)));
		end
		for (k = 0; k < 16; k++)
		begin
			send(r[15:0], 1, 1, 8'h00, k[3:0], k > 1);
			chk({DROP, VENDOR_SPECIFIC_ERROR_FLAG, RB_REQ}, 3'b110);
		end
		PORT_SHUT = 1;
		for (k = 0; k < 6; k++)
		begin
			r = $random(seed);
			STAT_ADDR = k[0] ? `IRL_SHUT_KEEP1 : `IRL_SHUT_KEEP0;
			STAT_ADDR = (k < 2) ? STAT_ADDR : r[11:0] | 12'h001;
			TBL_ADDR = r[20:12];
			@(posedge CLK) #1;
			chk(TBL_RD_PORT, 0);
			if (k < 2)
				chk({STAT_RDATA[31:2], STAT_RDATA[0]}, {14'h0, last_capt, 1'b0});
			else
				chk(STAT_RDATA, 0);
		end
		print_verdict;
	end
endmodule
`default_nettype wire
